// ---- core/fpls_pkg.sv ----
// package: constants and carrier types for the fp load/store conversion datapath
package fpls_pkg;

  // operation codes issued by dispatch
  typedef enum logic [2:0] {
    FPLS_OP_LOAD_S,
    FPLS_OP_LOAD_D,
    FPLS_OP_STORE_S,
    FPLS_OP_STORE_D,
    FPLS_OP_STORE_IW
  } fpls_op_t;

  localparam int          FPLS_ADDR_W      = 32;
  localparam int          FPLS_REG_CNT     = 32;
  localparam int          FPLS_REG_IDX_W   = 5;
  localparam logic [1:0]  FPLS_ALIGN_MASK  = 2'h3;
  localparam logic [10:0] FPLS_DENORM_EXP  = 11'h380;  // 896
  localparam logic [10:0] FPLS_EXP_BIAS_D  = 11'h3FF;
  localparam logic [7:0]  FPLS_EXP_BIAS_S  = 8'h7F;
  localparam logic [10:0] FPLS_BIAS_DIFF   = 11'h380;  // 1023 - 127
  localparam logic [10:0] FPLS_EXP_MAX_D   = 11'h7FF;
  localparam logic [7:0]  FPLS_EXP_MAX_S   = 8'hFF;
  localparam logic [4:0]  FPLS_SHIFT_MAX   = 5'h17;    // 23
  localparam logic [63:0] FPLS_REG_RESET   = 64'h0000000000000000;

  // request from dispatch
  typedef struct packed {
    fpls_op_t                  op;
    logic                      indexed;   // base + index, else base + displacement
    logic                      update;
    logic                      record_bit;
    logic [FPLS_REG_IDX_W-1:0] freg;      // destination or source float register
    logic [FPLS_ADDR_W-1:0]    base;
    logic [FPLS_ADDR_W-1:0]    index;
    logic [15:0]               disp;
    logic                      direct_store; // segment is direct-store
  } fpls_req_t;

  // answer to memory / dispatch
  typedef struct packed {
    logic                   valid;
    logic                   is_store;
    logic                   align_exc;
    logic                   cond_zero_undef; // condition_field_zero left undefined
    logic [FPLS_ADDR_W-1:0] ea;
    logic [63:0]            data;
    logic [1:0]             size;        // 0: word, 1: double word
  } fpls_rsp_t;

endpackage : fpls_pkg

// ---- core/fpls_core.sv ----
// fp load/store datapath: address, checks, precision conversion, shifter
//
// Functional notes
// - effective address is base plus displacement or base plus index
// - direct-store segment access is not done; alignment exception raised
// - single loads are widened to double before register write
// - effective address not word aligned raises alignment exception
// - indexed form with record bit set leaves condition_field_zero undefined
// - single stores narrow double register contents to single
// - integer-word store writes low register word, indexed addressing
// - store conversions are done here, not in the arithmetic unit
// - single store of double normal with exponent at most 896 is denormalized
// - denormalizing shifts mantissa right one bit per clock
// - denormalizing single store takes 1 to 23 extra cycles
// - all float registers hold double format, except single denormals, kept with a zero exponent field
// - double store of single denormal normalizes mantissa first
// - single loads, single arithmetic, round-to-single mark register single
// - normalizing shift always takes 23 cycles within the store
// - other double store operands pass unchanged
`timescale 1ns/10ps
module fpls_core
  import fpls_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      reset_i,
  input  wire logic                      req_valid_i,
  input  wire fpls_req_t                 req_i,
  input  wire logic                      fpu_wr_i,        // arithmetic unit writeback
  input  wire logic [FPLS_REG_IDX_W-1:0] fpu_wr_idx_i,
  input  wire logic [63:0]               fpu_wr_data_i,
  input  wire logic                      fpu_wr_single_i, // single arith or round-to-single
  input  wire logic                      load_data_valid_i,
  input  wire logic [63:0]               load_data_i,
  input  wire logic [FPLS_REG_IDX_W-1:0] rd_idx_i,
  output logic                           req_ready_o,
  output fpls_rsp_t                      rsp_o,
  output logic [63:0]                    rd_data_o
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SHIFT} fpls_state_t;

  fpls_state_t               state;
  logic [63:0]               float_register [FPLS_REG_CNT];
  logic [FPLS_REG_CNT-1:0]   single_tag;
  logic                      load_single;
  logic                      held_cond_undef;
  logic [FPLS_REG_IDX_W-1:0] load_idx;
  logic [52:0]               shift_mant;
  logic [4:0]                shift_left;
  logic                      shift_to_single;
  logic                      shift_sign;
  logic [10:0]               shift_exp;
  logic [FPLS_ADDR_W-1:0]    shift_ea;

  // ****************************************
  // request decode
  // ****************************************
  logic [FPLS_ADDR_W-1:0] next_ea;
  logic                   addr_bad;
  logic                   is_store;
  logic [63:0]            src;
  logic                   src_single;
  logic [10:0]            src_exp;
  logic [51:0]            src_frac;
  logic                   accept;

  // address generation and checks
  always_comb begin
    next_ea = req_i.indexed ? req_i.base + req_i.index
                            : req_i.base + {{16{req_i.disp[15]}}, req_i.disp};
    addr_bad = req_i.direct_store
             | ((next_ea[1:0] & FPLS_ALIGN_MASK) != 2'h0);
    is_store = (req_i.op != FPLS_OP_LOAD_S) && (req_i.op != FPLS_OP_LOAD_D);
    src        = float_register[req_i.freg];
    src_single = single_tag[req_i.freg];
    src_exp    = src[62:52];
    src_frac   = src[51:0];
  end

  assign accept = req_valid_i && (state == ST_IDLE);

  // single-precision view of a double register value, no rounding of kept bits
  function automatic logic [31:0] narrow(input logic [63:0] v);
    logic [10:0] e;
    e = v[62:52];
    if (e == 11'h000)
      narrow = {v[63], 8'h00, v[51:29]};  // single denormal; double denormals never get here
    else if (e == FPLS_EXP_MAX_D)
      narrow = {v[63], FPLS_EXP_MAX_S, v[51:29]};
    else
      narrow = {v[63], 8'(e - FPLS_BIAS_DIFF), v[51:29]};
  endfunction : narrow

  // widening of a single operand; single denormals keep a zero exponent field
  function automatic logic [63:0] widen(input logic [31:0] v);
    logic [7:0] e;
    e = v[30:23];
    if (e == 8'h00 && v[22:0] == 23'h000000)
      widen = {v[31], 63'h0000000000000000};
    else if (e == 8'h00)
      widen = {v[31], 11'h000, v[22:0], 29'h00000000};
    else if (e == FPLS_EXP_MAX_S)
      widen = {v[31], FPLS_EXP_MAX_D, v[22:0], 29'h00000000};
    else
      widen = {v[31], 11'({3'h0, e}) + FPLS_BIAS_DIFF, v[22:0], 29'h00000000};
  endfunction : widen

  // ****************************************
  // control sequencing
  // ****************************************
  // a single denormal register value is held with a zero exponent field and the
  // single tag set, so it can never be mistaken for a widened single normal
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (accept && !addr_bad) begin
            if (!is_store) begin
              state <= ST_LOAD;
            end else if (req_i.op == FPLS_OP_STORE_S && !src_single
                         && src_exp != 11'h000 && src_exp <= FPLS_DENORM_EXP) begin
              state <= ST_SHIFT;
            end else if (req_i.op == FPLS_OP_STORE_D && src_single
                         && src_exp == 11'h000 && src_frac != 52'h0) begin
              state <= ST_SHIFT;
            end
          end
        end
        ST_LOAD: begin
          if (load_data_valid_i) begin
            state <= ST_IDLE;
          end
        end
        ST_SHIFT: begin
          if (shift_left == 5'h01) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // shifter setup and stepping, one bit per clock
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      shift_mant      <= 53'h0;
      shift_left      <= 5'h00;
      shift_to_single <= 1'b0;
      shift_sign      <= 1'b0;
      shift_exp       <= 11'h000;
      shift_ea        <= '0;
    end else if (state == ST_IDLE && accept) begin
      shift_sign <= src[63];
      shift_ea   <= next_ea;
      if (req_i.op == FPLS_OP_STORE_S) begin
        // exponent 896 needs one step, each lower value one more, capped at 23
        shift_to_single <= 1'b1;
        // below the smallest single denormal every kept bit truncates away
        shift_mant      <= (FPLS_DENORM_EXP - src_exp >= 11'(FPLS_SHIFT_MAX))
                           ? 53'h0
                           : {1'b1, src_frac};
        shift_left      <= (FPLS_DENORM_EXP - src_exp >= 11'(FPLS_SHIFT_MAX - 5'h01))
                           ? FPLS_SHIFT_MAX
                           : 5'(FPLS_DENORM_EXP - src_exp) + 5'h01;
      end else begin
        shift_to_single <= 1'b0;
        shift_mant      <= {1'b0, src_frac};
        shift_exp       <= FPLS_BIAS_DIFF + 11'h001;
        shift_left      <= FPLS_SHIFT_MAX;
      end
    end else if (state == ST_SHIFT) begin
      shift_left <= shift_left - 5'h01;
      if (shift_to_single) begin
        shift_mant <= {1'b0, shift_mant[52:1]};
      end else if (!shift_mant[52]) begin
        shift_mant <= {shift_mant[51:0], 1'b0};
        shift_exp  <= shift_exp - 11'h001;
      end
    end
  end

  // ****************************************
  // register file and precision tags
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      load_single <= 1'b0;
      load_idx    <= '0;
      held_cond_undef <= 1'b0;
    end else if (accept) begin
      load_single <= (req_i.op == FPLS_OP_LOAD_S);
      load_idx    <= req_i.freg;
      held_cond_undef <= req_i.indexed && req_i.record_bit;  // late answers keep the flag
    end
  end

  // load writeback has priority over arithmetic writeback to the same register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      single_tag <= '0;
      for (int i = 0; i < FPLS_REG_CNT; i++) begin
        float_register[i] <= FPLS_REG_RESET;
      end
    end else begin
      if (fpu_wr_i) begin
        float_register[fpu_wr_idx_i] <= fpu_wr_data_i;
        single_tag[fpu_wr_idx_i]     <= fpu_wr_single_i;
      end
      if (state == ST_LOAD && load_data_valid_i) begin
        float_register[load_idx] <= load_single ? widen(load_data_i[31:0])
                                                : load_data_i;
        single_tag[load_idx]     <= load_single;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // store data conversion lives here rather than in the arithmetic unit
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rsp_o       <= '0;
      req_ready_o <= 1'b0;
      rd_data_o   <= 64'h0;
    end else begin
      rd_data_o   <= float_register[rd_idx_i];
      req_ready_o <= (state == ST_IDLE) && !accept;
      rsp_o       <= '0;
      if (accept) begin
        rsp_o.cond_zero_undef <= req_i.indexed && req_i.record_bit;
        rsp_o.ea        <= next_ea;
        rsp_o.is_store  <= is_store;
        if (addr_bad) begin
          rsp_o.valid     <= 1'b1;
          rsp_o.align_exc <= 1'b1;
        end else if (is_store) begin
          rsp_o.valid <= 1'b1;
          unique case (req_i.op)
            FPLS_OP_STORE_S: begin
              rsp_o.size <= 2'h0;
              if (!src_single && src_exp == 11'h000) begin
                rsp_o.data <= {32'h0, src[63], 31'h00000000};
              end else if (!src_single && src_exp <= FPLS_DENORM_EXP) begin
                rsp_o.valid <= 1'b0;
              end else begin
                rsp_o.data <= {32'h0, narrow(src)};
              end
            end
            FPLS_OP_STORE_D: begin
              rsp_o.size <= 2'h1;
              if (src_single && src_exp == 11'h000 && src_frac != 52'h0) begin
                rsp_o.valid <= 1'b0;
              end else begin
                rsp_o.data <= src;
              end
            end
            FPLS_OP_STORE_IW: begin
              rsp_o.size <= 2'h0;
              rsp_o.data <= {32'h0, src[31:0]};
            end
            default: begin
              rsp_o.size <= 2'h0;
            end
          endcase
        end
      end else if (state == ST_LOAD && load_data_valid_i) begin
        rsp_o.valid <= 1'b1;                                              // load done
        rsp_o.cond_zero_undef <= held_cond_undef;
      end else if (state == ST_SHIFT && shift_left == 5'h01) begin
        rsp_o.valid    <= 1'b1;
        rsp_o.is_store <= 1'b1;
        rsp_o.ea       <= shift_ea;
        rsp_o.cond_zero_undef <= held_cond_undef;
        if (shift_to_single) begin
          rsp_o.size <= 2'h0;
          rsp_o.data <= {32'h0, shift_sign, 8'h00, shift_mant[52:30]};
        end else begin
          rsp_o.size <= 2'h1;
          rsp_o.data <= shift_mant[52]
                        ? {shift_sign, shift_exp, shift_mant[51:0]}
                        : {shift_sign, shift_exp - 11'h001, shift_mant[50:0], 1'b0};
        end
      end
    end
  end

endmodule : fpls_core

// ---- dv/fpls_checker.sv ----
// checker: port-level properties of the fp load/store datapath
`timescale 1ns/10ps
module fpls_checker
  import fpls_pkg::*;
(
  input wire logic      clk_i,
  input wire logic      reset_i,
  input wire logic      req_valid_i,
  input wire fpls_req_t req_i,
  input wire logic      load_data_valid_i,
  input wire logic      req_ready_o,
  input wire fpls_rsp_t rsp_o
);
  // ****************
  // request capture
  // ****************
  logic [31:0] ea_c;
  logic [31:0] last_ea;
  logic        last_cr;
  fpls_op_t    last_op;
  logic        take;
  logic        bad;
  // address rebuilt here so every answer can be tied back to its cause
  assign ea_c = req_i.base + (req_i.indexed ? req_i.index
                                            : {{16{req_i.disp[15]}}, req_i.disp});
  assign take = req_valid_i && req_ready_o;
  assign bad  = (ea_c[1:0] != 2'h0) || req_i.direct_store;
  // remember the last taken request; shifting stores answer many cycles later
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      last_ea <= 32'h0;
      last_cr <= 1'b0;
      last_op <= FPLS_OP_LOAD_S;
    end else if (take) begin
      last_ea <= ea_c;
      last_cr <= req_i.indexed && req_i.record_bit;
      last_op <= req_i.op;
    end
  end
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence good_store_s;
    take && !bad && (req_i.op inside {FPLS_OP_STORE_S, FPLS_OP_STORE_D, FPLS_OP_STORE_IW});
  endsequence
  sequence store_answer_s;
    ##[1:24] (rsp_o.valid && rsp_o.is_store && !rsp_o.align_exc);
  endsequence
  misalign_exc_a: assert property (take && ea_c[1:0] != 2'h0 |=> rsp_o.valid && rsp_o.align_exc)
    else $error("misaligned request without alignment exception");
  direct_exc_a: assert property (take && req_i.direct_store |=> rsp_o.valid && rsp_o.align_exc)
    else $error("direct-store request without alignment exception");
  store_ea_a: assert property (rsp_o.valid && rsp_o.is_store && !rsp_o.align_exc |-> rsp_o.ea == last_ea)
    else $error("store address differs from request");
  cond_flag_a: assert property (rsp_o.valid && !rsp_o.align_exc |-> rsp_o.cond_zero_undef == last_cr)
    else $error("condition field flag wrong");
  iword_size_a: assert property (take && !bad && req_i.op == FPLS_OP_STORE_IW |=> rsp_o.valid && rsp_o.size == 2'h0)
    else $error("integer word store answer wrong");
  store_bound_a: assert property (good_store_s |-> store_answer_s)
    else $error("store answer late");
  load_answer_a: assert property (load_data_valid_i && !req_ready_o |=> rsp_o.valid && !rsp_o.is_store)
    else $error("load answer missing");
  store_size_a: assert property (rsp_o.valid && rsp_o.is_store && !rsp_o.align_exc |-> rsp_o.size == {1'b0, last_op == FPLS_OP_STORE_D})
    else $error("store size wrong");
endmodule : fpls_checker

bind fpls_core fpls_checker fpls_checker_inst (.clk_i(clk_i), .reset_i(reset_i),
  .req_valid_i(req_valid_i), .req_i(req_i), .load_data_valid_i(load_data_valid_i),
  .req_ready_o(req_ready_o), .rsp_o(rsp_o));

// ---- dv/fpls_mem_model.sv ----
// partner: data cache side answering fp loads after a chosen delay
`timescale 1ns/10ps
module fpls_mem_model
  import fpls_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        req_valid_i,
  input  wire fpls_req_t   req_i,
  input  wire logic [3:0]  delay_i,
  input  wire logic [63:0] word_i,
  output logic             load_data_valid_o,
  output logic [63:0]      load_data_o
);
  // ****************
  // cache answer
  // ****************
  logic [3:0]  cnt;
  logic [31:0] ea;
  assign ea = req_i.base + (req_i.indexed ? req_i.index : {{16{req_i.disp[15]}}, req_i.disp});
  // a refused address never reaches the cache, so nothing comes back for it
  always_ff @(posedge clk_i) begin
    if (reset_i) cnt <= 4'h0;
    else if (req_valid_i && req_i.op inside {FPLS_OP_LOAD_S, FPLS_OP_LOAD_D}
             && ea[1:0] == 2'h0 && !req_i.direct_store) cnt <= delay_i;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
  // data line is not held: outside the pulse it toggles so stale data cannot pass
  always_ff @(posedge clk_i) begin
    load_data_valid_o <= !reset_i && cnt == 4'h1;
    load_data_o       <= (cnt == 4'h1) ? word_i : ~load_data_o;
  end
endmodule : fpls_mem_model

// ---- dv/tb_top.sv ----
// testbench: fp load/store traffic checked against a reference model
`timescale 1ns/10ps
module tb_top;
  import fpls_pkg::*;
  // ****************
  // signals and model state
  // ****************
  logic        clk_i = 1'b0, reset_i = 1'b1, req_valid_i = 1'b0, fpu_wr_i = 1'b0;
  logic        fpu_wr_single_i = 1'b0, load_data_valid_i, req_ready_o;
  logic [4:0]  fpu_wr_idx_i = 5'h00, rd_idx_i = 5'h00;
  logic [63:0] fpu_wr_data_i = 64'h0, load_data_i, rd_data_o, word = 64'h0;
  logic [3:0]  delay = 4'h1;
  logic [63:0] dv [32];
  logic [63:0] rw [32];
  logic [31:0] sspec [6] = '{32'h00012345, 32'h80000001, 32'h7F800000, 32'h0, 32'h7FC00001,
                             32'h0};
  logic [63:0] dspec [3] = '{64'h8000000000000000, 64'hFFF0000000000000, 64'h7FF8000000000001};
  logic [31:0] sv [32];
  bit          st [32];
  fpls_req_t   req_i = '0;
  fpls_rsp_t   rsp_o, r;
  int          errors = 0, compares = 0, lat;
  integer      seed = 32'hE1E71F3F;
  logic [10:0] exps [7] = '{11'h400, 11'h381, 11'h380, 11'h370, 11'h36A, 11'h300, 11'h000};
  fpls_core fpls_core_inst (.clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .fpu_wr_i(fpu_wr_i), .fpu_wr_idx_i(fpu_wr_idx_i),
    .fpu_wr_data_i(fpu_wr_data_i), .fpu_wr_single_i(fpu_wr_single_i),
    .load_data_valid_i(load_data_valid_i), .load_data_i(load_data_i), .rd_idx_i(rd_idx_i),
    .req_ready_o(req_ready_o), .rsp_o(rsp_o), .rd_data_o(rd_data_o));
  fpls_mem_model fpls_mem_model_inst (.clk_i(clk_i), .reset_i(reset_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .delay_i(delay), .word_i(word),
    .load_data_valid_o(load_data_valid_i), .load_data_o(load_data_i));
  always #25 clk_i = ~clk_i;
  // ****************
  // model functions and tasks
  // ****************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : check
  // canonical double of a single word; denormals come out normalised
  function automatic logic [63:0] widen(input logic [31:0] s);
    int p;
    p = 0;
    for (int i = 0; i < 23; i++) if (s[i]) p = i;
    if (s[30:23] == 8'hFF) return {s[31], 11'h7FF, s[22:0], 29'h0};
    if (s[30:23] != 8'h00) return {s[31], {3'h0, s[30:23]} + 11'h380, s[22:0], 29'h0};
    if (s[22:0] == 23'h0) return {s[31], 63'h0};
    return {s[31], 11'(p) + 11'h36A, 52'(52'(s[22:0]) << (52 - p))};
  endfunction : widen
  // single word of a double-tagged register plus expected answer latency n
  function automatic logic [31:0] narrow(input logic [63:0] d, output int n);
    int k;
    logic [23:0] m;
    n = 1;
    k = 897 - int'(d[62:52]);
    m = {1'b1, d[51:29]} >> k;
    if (d[62:52] == 11'h000) return {d[63], 31'h0};
    if (d[62:52] == 11'h7FF) return {d[63], 8'hFF, d[51:29]};
    if (k < 1) return {d[63], 8'(d[62:52] - 11'h380), d[51:29]};
    n = 1 + ((k > 23) ? 23 : k);
    return {d[63], 8'h00, m[22:0]};
  endfunction : narrow
  task automatic issue(input fpls_op_t op, input logic [4:0] fr, input logic [31:0] b, x,
                       input logic [15:0] dp, input logic ix, rec, ds);
    @(negedge clk_i);
    req_i = '{op: op, indexed: ix, update: 1'b0, record_bit: rec, freg: fr, base: b,
              index: x, disp: dp, direct_store: ds};
    req_valid_i = 1'b1;
    lat = 0;
    r = '0;
    // the answer stands one cycle only, so it is read at the falling edge after it appears
    while (r.valid !== 1'b1 && lat < 60) begin
      @(negedge clk_i);
      req_valid_i = 1'b0;
      r = rsp_o;
      lat++;
    end
  endtask : issue
  task automatic load(input fpls_op_t op, input logic [4:0] i, input logic [63:0] w);
    logic rec;
    rec = 1'($random(seed));
    word = w;
    delay = 4'h1 + {2'h0, 2'($random(seed))};
    issue(op, i, 32'($random(seed)) & 32'hFFFFFFFC, 32'h0, 16'h0, 1'b1, rec, 1'b0);
    check({r.valid, r.align_exc, r.is_store, r.cond_zero_undef}, {3'h4, rec}, "load answer");
    st[i] = (op == FPLS_OP_LOAD_S);
    sv[i] = w[31:0];
    dv[i] = st[i] ? widen(w[31:0]) : w;
    if (!st[i] || w[30:23] != 8'h00) begin
      @(negedge clk_i);
      rd_idx_i = i;
      @(negedge clk_i);
      check(rd_data_o, dv[i], "register read");
    end
  endtask : load
  task automatic store(input fpls_op_t op, input logic [4:0] i);
    logic [63:0] e;
    logic [31:0] ea, x;
    logic [15:0] dp;
    logic ix, rec;
    int n;
    n = 1;
    ea = 32'($random(seed)) & 32'hFFFFFFFC;
    x = $random(seed);
    dp = 16'($random(seed));
    ix = (op == FPLS_OP_STORE_IW) || 1'($random(seed));
    rec = 1'($random(seed));
    e = (op == FPLS_OP_STORE_D) ? dv[i] : {32'h0, st[i] ? sv[i] : narrow(dv[i], n)};
    if (op == FPLS_OP_STORE_IW) begin
      e = {32'h0, rw[i][31:0]};
      n = 1;
    end
    if (op == FPLS_OP_STORE_D) n = (st[i] && sv[i][30:23] == 8'h00 && sv[i][22:0] != 0) ? 24 : 1;
    issue(op, i, ea - (ix ? x : {{16{dp[15]}}, dp}), x, dp, ix, rec, 1'b0);
    check({r.valid, r.is_store, r.align_exc, r.cond_zero_undef}, {3'h6, ix & rec}, "store status");
    check(r.ea, ea, "store address");
    check((op == FPLS_OP_STORE_D) ? r.data : {32'h0, r.data[31:0]}, e, "store data");
    check(lat, n, "store cycles");
  endtask : store
  task automatic end_sim;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  // ****************
  // test sequence
  // ****************
  // watchdog sized well above the few hundred cycles the sequence needs
  initial begin
    #(50 * 40000);
    errors++;
    end_sim();
  end
  initial begin
    logic [31:0] s;
    repeat (12) @(negedge clk_i);
    reset_i = 1'b0;
    for (int i = 0; i < 14; i++) begin
      s = $random(seed);
      s[30] = (s[30:23] == 8'h00 || s[30:23] == 8'hFF) ? ~s[30] : s[30];
      if (i > 7) s = sspec[i - 8];
      load((i == 13) ? FPLS_OP_LOAD_D : FPLS_OP_LOAD_S, 5'(i), {32'($random(seed)), s});
    end
    for (int i = 0; i < 14; i++) begin
      store(FPLS_OP_STORE_S, 5'(i));
      store(FPLS_OP_STORE_D, 5'(i));
    end
    $display("test loads and converted stores done");
    for (int i = 0; i < 11; i++) begin
      @(negedge clk_i);
      fpu_wr_i = 1'b1;
      fpu_wr_idx_i = 5'(16 + i);
      fpu_wr_single_i = (i == 10);
      fpu_wr_data_i = {1'($random(seed)), exps[i % 7], 52'($random(seed))};
      if (i > 6 && i < 10) fpu_wr_data_i = dspec[i - 7];
      // single arithmetic denormal: zero exponent field, nonzero fraction, tagged single
      if (i == 10) fpu_wr_data_i = {fpu_wr_data_i[63], 11'h000, fpu_wr_data_i[51:30], 1'b1, 29'h0};
      st[16 + i] = (i == 10);
      sv[16 + i] = {fpu_wr_data_i[63], 8'h00, fpu_wr_data_i[51:29]};
      rw[16 + i] = fpu_wr_data_i;
      dv[16 + i] = st[16 + i] ? widen(sv[16 + i]) : fpu_wr_data_i;
      @(negedge clk_i);
      fpu_wr_i = 1'b0;
      store(FPLS_OP_STORE_S, 5'(16 + i));
      store(FPLS_OP_STORE_D, 5'(16 + i));
      store(FPLS_OP_STORE_IW, 5'(16 + i));
    end
    $display("test double register stores done");
    for (int k = 0; k < 20; k++) begin
      issue(fpls_op_t'(k % 5), 5'h10, (32'($random(seed)) & 32'hFFFFFFFC) | 32'(k / 5), 32'h0,
            16'h0, 1'b1, 1'b0, k < 5);
      check({r.valid, r.align_exc, 6'(lat)}, 8'hC1, "refused access");
    end
    $display("test alignment and direct-store done");
    end_sim();
  end
endmodule : tb_top
